// >>> spl_switch_cfg.sv
`timescale 1ns/10ps
`default_nettype none
`include "spl_consts.svh"

module spl_switch_cfg
  import spl_pkg::*;
#(
  parameter int NUM_PORTS = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [6:0]       wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic             wb_we_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  wb_err_o,
  input  wire spl_port_status_t port_stat_i [NUM_PORTS],
  output logic [3:0]            port_ind_o  [NUM_PORTS],
  input  wire spl_frame_req_t   frame_req_i,
  output spl_frame_ans_t        frame_ans_o
);

  localparam logic [15:0] IND_RST = `SPL_RST_IND_MODE;
  localparam logic [15:0] TAG_RST = `SPL_RST_TAG_MAP;

  typedef enum logic [1:0] {
    SPL_BUS_IDLE = 2'b00,
    SPL_BUS_ACK  = 2'b01,
    SPL_BUS_ERR  = 2'b10
  } spl_bus_state_t;

  spl_bus_state_t bus_state;
  spl_bus_state_t next_bus_state;
  logic [15:0]    ind_mode_cfg;
  logic [15:0]    tag_map;
  spl_mode_t      mode;
  logic           req;
  logic           aligned;
  logic           hit_ind;
  logic           hit_tag;
  logic           wr_lo;
  logic           wr_hi;
  logic           wr_ind_lo;
  logic           wr_ind_hi;
  logic           wr_tag_lo;
  logic           wr_tag_hi;
  logic           rd;
  logic [15:0]    next_rd_word;
  logic           indicator_mode_sel_hi;
  logic           indicator_mode_sel_lo;
  logic [2:0]     ind_rsvd_14_12;
  logic [1:0]     ind_rsvd_11_10;
  logic           ind_rsvd_8;
  logic [7:0]     ind_rsvd_7_0;
  logic [1:0]     prio_for_tag_seven;
  logic [1:0]     prio_for_tag_six;
  logic [1:0]     prio_for_tag_five;
  logic [1:0]     prio_for_tag_four;
  logic [1:0]     prio_for_tag_three;
  logic [1:0]     prio_for_tag_two;
  logic [1:0]     prio_for_tag_one;
  logic [1:0]     prio_for_tag_zero;
  logic [1:0]     next_prio;

  // One request at a time; a new one waits until the answer has gone
  assign req     = wb_cyc_i & wb_stb_i & (bus_state == SPL_BUS_IDLE);
  assign aligned = (wb_adr_i[1:0] == 2'h0);
  assign hit_ind = (wb_adr_i[6:2] == `SPL_IDX_IND_MODE) & aligned;
  assign hit_tag = (wb_adr_i[6:2] == `SPL_IDX_TAG_MAP) & aligned;
  assign wr_lo   = req & wb_we_i & wb_sel_i[0];
  assign wr_hi   = req & wb_we_i & wb_sel_i[1];
  assign rd      = req & ~wb_we_i;
  // Byte lanes 2 and 3 carry nothing
  assign wr_ind_lo = hit_ind & wr_lo;
  assign wr_ind_hi = hit_ind & wr_hi;
  assign wr_tag_lo = hit_tag & wr_lo;
  assign wr_tag_hi = hit_tag & wr_hi;

  always_comb begin
    next_bus_state = SPL_BUS_IDLE;
    case (bus_state)
      SPL_BUS_IDLE: begin
        if (req & (hit_ind | hit_tag)) begin
          next_bus_state = SPL_BUS_ACK;
        end else if (req) begin
          // Unmapped addresses end with err so the master never hangs
          next_bus_state = SPL_BUS_ERR;
        end else begin
          next_bus_state = SPL_BUS_IDLE;
        end
      end
      SPL_BUS_ACK: begin
        next_bus_state = SPL_BUS_IDLE;
      end
      SPL_BUS_ERR: begin
        next_bus_state = SPL_BUS_IDLE;
      end
      default: begin
        next_bus_state = SPL_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= SPL_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Answers come from the state, so each stands one cycle
  assign wb_ack_o = (bus_state == SPL_BUS_ACK);
  assign wb_err_o = (bus_state == SPL_BUS_ERR);

  always_comb begin
    next_rd_word = 16'h0000;
    if (hit_ind) begin
      next_rd_word = ind_mode_cfg;
    end else if (hit_tag) begin
      next_rd_word = tag_map;
    end else begin
      next_rd_word = 16'h0000;
    end
  end

  // Read data stands only in the answer cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= {16'h0000, next_rd_word};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // Mode selector bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      indicator_mode_sel_hi <= IND_RST[`SPL_BIT_SEL_HI];
    end else if (wr_ind_hi) begin
      indicator_mode_sel_hi <= wb_dat_i[`SPL_BIT_SEL_HI];
    end
  end

  // Reserved bits read back what software wrote
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_rsvd_14_12 <= IND_RST[14:12];
    end else if (wr_ind_hi) begin
      ind_rsvd_14_12 <= wb_dat_i[14:12];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_rsvd_11_10 <= IND_RST[11:10];
    end else if (wr_ind_hi) begin
      ind_rsvd_11_10 <= wb_dat_i[11:10];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      indicator_mode_sel_lo <= IND_RST[`SPL_BIT_SEL_LO];
    end else if (wr_ind_hi) begin
      indicator_mode_sel_lo <= wb_dat_i[`SPL_BIT_SEL_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_rsvd_8 <= IND_RST[8];
    end else if (wr_ind_hi) begin
      ind_rsvd_8 <= wb_dat_i[8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_rsvd_7_0 <= IND_RST[7:0];
    end else if (wr_ind_lo) begin
      ind_rsvd_7_0 <= wb_dat_i[7:0];
    end
  end

  assign ind_mode_cfg = {indicator_mode_sel_hi, ind_rsvd_14_12,
                         ind_rsvd_11_10, indicator_mode_sel_lo,
                         ind_rsvd_8, ind_rsvd_7_0};

  // Defaults 3,3,2,2,1,1,0,0 from tag 7 down to tag 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_for_tag_seven <= TAG_RST[15:14];
    end else if (wr_tag_hi) begin
      prio_for_tag_seven <= wb_dat_i[15:14];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_for_tag_six <= TAG_RST[13:12];
    end else if (wr_tag_hi) begin
      prio_for_tag_six <= wb_dat_i[13:12];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_for_tag_five <= TAG_RST[11:10];
    end else if (wr_tag_hi) begin
      prio_for_tag_five <= wb_dat_i[11:10];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_for_tag_four <= TAG_RST[9:8];
    end else if (wr_tag_hi) begin
      prio_for_tag_four <= wb_dat_i[9:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_for_tag_three <= TAG_RST[7:6];
    end else if (wr_tag_lo) begin
      prio_for_tag_three <= wb_dat_i[7:6];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_for_tag_two <= TAG_RST[5:4];
    end else if (wr_tag_lo) begin
      prio_for_tag_two <= wb_dat_i[5:4];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_for_tag_one <= TAG_RST[3:2];
    end else if (wr_tag_lo) begin
      prio_for_tag_one <= wb_dat_i[3:2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_for_tag_zero <= TAG_RST[1:0];
    end else if (wr_tag_lo) begin
      prio_for_tag_zero <= wb_dat_i[1:0];
    end
  end

  assign tag_map = {prio_for_tag_seven, prio_for_tag_six,
                    prio_for_tag_five, prio_for_tag_four,
                    prio_for_tag_three, prio_for_tag_two,
                    prio_for_tag_one, prio_for_tag_zero};

  // Mode 11 leaves every indicator dark
  assign mode = spl_mode_t'({indicator_mode_sel_hi,
                             indicator_mode_sel_lo});

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    spl_indicator_mux u_mux (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .mode_i (mode),
      .stat_i (port_stat_i[p]),
      .ind_o  (port_ind_o[p])
    );
  end

  always_comb begin
    next_prio = prio_for_tag_zero;
    case (frame_req_i.tag_prio)
      3'h7: begin
        next_prio = prio_for_tag_seven;
      end
      3'h6: begin
        next_prio = prio_for_tag_six;
      end
      3'h5: begin
        next_prio = prio_for_tag_five;
      end
      3'h4: begin
        next_prio = prio_for_tag_four;
      end
      3'h3: begin
        next_prio = prio_for_tag_three;
      end
      3'h2: begin
        next_prio = prio_for_tag_two;
      end
      3'h1: begin
        next_prio = prio_for_tag_one;
      end
      default: begin
        next_prio = prio_for_tag_zero;
      end
    endcase
  end

  // Valid kept apart; priority is a don't-care while no frame is offered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_ans_o.valid <= 1'b0;
    end else begin
      frame_ans_o.valid <= frame_req_i.valid;
    end
  end

  // Lookup registered; a map write lands on frames one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_ans_o.prio <= 2'h0;
    end else begin
      frame_ans_o.prio <= next_prio;
    end
  end

endmodule

`default_nettype wire

// >>> spl_consts.svh
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH

// Register index as printed; byte address is four times the index
`define SPL_IDX_TAG_MAP        5'h00
`define SPL_IDX_IND_MODE       5'h0A
`define SPL_ADDR_TAG_MAP       7'h00
`define SPL_ADDR_IND_MODE      7'h28

`define SPL_BIT_SEL_HI         15
`define SPL_BIT_SEL_LO         9

`define SPL_RST_IND_MODE       16'h0835
`define SPL_RST_TAG_MAP        16'hFA50
`define SPL_PRIO_W             2

`endif

// >>> spl_pkg.sv
package spl_pkg;

  typedef enum logic [1:0] {
    SPL_MODE_A = 2'b00,
    SPL_MODE_B = 2'b01,
    SPL_MODE_C = 2'b10,
    SPL_MODE_D = 2'b11
  } spl_mode_t;

  typedef struct packed {
    logic link;
    logic act;
    logic full_dpx;
    logic col;
    logic speed_100;
  } spl_port_status_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] tag_prio;
  } spl_frame_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] prio;
  } spl_frame_ans_t;

endpackage

// >>> spl_indicator_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "spl_consts.svh"

module spl_indicator_mux
  import spl_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire spl_mode_t        mode_i,
  input  wire spl_port_status_t stat_i,
  output logic [3:0]            ind_o
);

  logic [3:0] next_ind;

  always_comb begin
    next_ind = 4'h0;
    case (mode_i)
      SPL_MODE_A: begin
        next_ind[2] = stat_i.link | stat_i.act;
        next_ind[1] = stat_i.full_dpx | stat_i.col;
        next_ind[0] = stat_i.speed_100;
      end
      SPL_MODE_B: begin
        next_ind[2] = stat_i.speed_100 & (stat_i.link | stat_i.act);
        next_ind[1] = ~stat_i.speed_100 & (stat_i.link | stat_i.act);
        next_ind[0] = stat_i.full_dpx;
      end
      SPL_MODE_C: begin
        next_ind[3] = stat_i.act;
        next_ind[2] = stat_i.link;
        next_ind[1] = stat_i.full_dpx | stat_i.col;
        next_ind[0] = stat_i.speed_100;
      end
      // Mode 11 has no defined meaning; indicators stay dark
      default: next_ind = 4'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_o <= 4'h0;
    end else begin
      ind_o <= next_ind;
    end
  end

endmodule

`default_nettype wire

// >>> spl_switch_cfg_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "spl_consts.svh"
module spl_cfg_chk
  import spl_pkg::*;
(
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic [6:0]     wb_adr_i,
  input wire logic [31:0]    wb_dat_i,
  input wire logic [3:0]     wb_sel_i,
  input wire logic           wb_we_i,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic [31:0]    wb_dat_o,
  input wire logic           wb_ack_o,
  input wire logic           wb_err_o,
  input wire spl_frame_req_t frame_req_i,
  input wire spl_frame_ans_t frame_ans_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        req;
  logic        hit;
  logic [1:0]  pick;
  logic [15:0] tmap;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign hit = wb_adr_i == `SPL_ADDR_TAG_MAP || wb_adr_i == `SPL_ADDR_IND_MODE;
  assign pick = tmap[2*frame_req_i.tag_prio +: 2];
  // Shadow of the map, so answers follow software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmap <= 16'hFA50;
    end else if (req && wb_we_i && wb_adr_i == `SPL_ADDR_TAG_MAP) begin
      if (wb_sel_i[0]) tmap[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) tmap[15:8] <= wb_dat_i[15:8];
    end
  end
  sequence s_take;
    req && hit;
  endsequence
  AST_ACK: assert property (s_take |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  AST_ERR: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ERR_ONE: assert property (wb_err_o |=> !wb_err_o)
    else $error("err too long");
  AST_HI: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half set");
  AST_FV: assert property (frame_req_i.valid |=> frame_ans_o.valid)
    else $error("frame unanswered");
  AST_FN: assert property (!frame_req_i.valid |=> !frame_ans_o.valid)
    else $error("answer without frame");
  AST_TAG: assert property (frame_req_i.valid |=> frame_ans_o.prio == $past(pick))
    else $error("wrong frame priority");
endmodule
bind spl_switch_cfg spl_cfg_chk chk_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
  .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .wb_err_o, .frame_req_i, .frame_ans_o);
`default_nettype wire

// >>> spl_switch_cfg_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module spl_switch_cfg_tb import spl_pkg::*;;
  logic             clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
  logic             ack, err, qe;
  logic [6:0]       adr = 0;
  logic [3:0]       sel = 0;
  logic [31:0]      dat = 0, dq, q;
  spl_frame_req_t   req = 0;
  spl_frame_ans_t   ans;
  spl_port_status_t st[2] = '{5'h13, 5'h0C};
  logic [3:0]       ind[2];
  int               failures = 0, n_compared = 0, cyc_n = 0;
  always #50 clk_i = ~clk_i;
  spl_switch_cfg dut_u (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(dq), .wb_ack_o(ack), .wb_err_o(err), .port_stat_i(st),
    .port_ind_o(ind), .frame_req_i(req), .frame_ans_o(ans));
  task automatic wb(input logic [6:0] a, input logic w, input logic [3:0] s,
                    input logic [15:0] d);
    @(posedge clk_i);
    adr <= a;
    we <= w;
    sel <= s;
    dat <= {16'h0000, d};
    cyc <= 1;
    stb <= 1;
    @(posedge clk_i);
    while (!(ack | err)) @(posedge clk_i);
    q = dq;
    qe = err;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic frm(input logic [2:0] t, input logic [1:0] p);
    @(posedge clk_i);
    req <= {1'b1, t};
    @(posedge clk_i);
    req <= 0;
    @(posedge clk_i);
    `CHK("prio", {1'b1, p}, ans)
  endtask
  task automatic t_map;
    logic [15:0] m;
    m = 16'hFA50;
    for (int k = 0; k < 2; k++) begin
      wb(7'h00, 0, 4'h3, 0);
      `CHK("map", {16'h0000, m}, q)
      for (int t = 0; t < 8; t++) frm(t[2:0], m[2*t +: 2]);
      // Low lane only: upper fields must survive
      wb(7'h00, 1, 4'h1, 16'h1B4E);
      m = 16'hFA4E;
    end
    $display("test map done");
  endtask
  task automatic t_ind;
    logic [15:0] mv[4] = '{16'h2035, 16'h2235, 16'hA035, 16'hA235};
    logic [7:0]  ex[4] = '{8'h67, 8'h34, 8'hA7, 8'h00};
    wb(7'h28, 0, 4'h3, 0);
    `CHK("mode reg", 32'h00000835, q)
    for (int i = 0; i < 4; i++) begin
      wb(7'h28, 1, 4'h3, mv[i]);
      repeat (2) @(posedge clk_i);
      `CHK("ind", ex[i], {ind[1], ind[0]})
    end
    wb(7'h04, 0, 4'h3, 0);
    `CHK("err", 1'b1, qe)
    $display("test ind done");
  endtask
  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_map;
    t_ind;
    report_and_stop;
  end
endmodule
`default_nettype wire
